//--- rtl/isb_defines.vh
// Constants for the stacked expansion bus upper-row host controller
`ifndef ISB_DEFINES_VH
`define ISB_DEFINES_VH
// Bus cycle phase lengths in clock cycles
`define ISB_ADDR_CYCLES    3'h1
// Command phase outlasts the ready synchroniser, so a wait request is seen in time
`define ISB_CMD_CYCLES     3'h4
`define ISB_WAIT_MAX       8'hFF
// DMA channel count and acknowledge idle value (active low)
`define ISB_DMA_CHANNELS   8
`define ISB_DACK_IDLE      8'hFF
// Upper address field of the 24-bit bus address
`define ISB_LA_HI          23
`define ISB_LA_LO          17
// Terminal count pulse length in cycles
`define ISB_TC_CYCLES      2'h1
`endif

//--- rtl/isb_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module isb_sync
#(
    parameter WIDTH = 1
)
(
    // Clock and control
    input  wire             clock,
    input  wire             reset,
    input  wire             clk_en,
    // Data
    input  wire [WIDTH-1:0] async_in,
    input  wire [WIDTH-1:0] reset_val,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;
    reg [WIDTH-1:0] s3_reg;
    genvar i;

    always @(posedge clock)
    begin
        if (reset)
        begin
            // Stages start at the idle level so no false change follows reset
            s1_reg <= reset_val;
            s2_reg <= reset_val;
            s3_reg <= reset_val;
        end
        else if (clk_en)
        begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Change accepted only once stages two and three agree
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            always @(posedge clock)
            begin
                if (reset)
                    sync_out[i] <= reset_val[i];
                else if (clk_en && (s2_reg[i] == s3_reg[i]))
                    sync_out[i] <= s3_reg[i];
            end
        end
    endgenerate
endmodule

//--- rtl/isb_host.v
// Host side of the stacked expansion bus: upper rows, DMA and master takeover
// Operation
// - The bus owner drives the byte-high enable low whenever a transfer uses data lines 15 to 8.
// - The host asserts memory read on every memory read cycle over the whole range.
// - The host asserts memory write on every memory write cycle over the whole range.
// - The host DMA controller asserts an active-low acknowledge to select the requester.
// - The host supplies the oscillator clock, which is asynchronous to the bus clock; the code re-times osc_out to the bus clock.
// - Upper address is latched on the falling edge of the latch enable, held high during DMA; the code drops it low once a master takes over.
// - The host pulses terminal count when a DMA channel operation is complete.
`timescale 1ns/1ps
`include "isb_defines.vh"
module isb_host
(
    // Clock, reset, enable
    input  wire        clock,
    input  wire        reset,
    input  wire        clk_en,
    input  wire        osc_in,
    // Processor side request
    input  wire        cpu_req,
    input  wire        cpu_write,
    input  wire [23:0] cpu_addr,
    input  wire [15:0] cpu_wdata,
    input  wire        cpu_word,
    output reg         cpu_done,
    output reg  [15:0] cpu_rdata,
    output reg         cpu_wide,
    // DMA completion control and interrupt pending
    input  wire [7:0]  dma_last,
    output reg  [7:0]  irq_pending,
    // Bus address and strobes
    output reg  [23:17] la_out,
    output reg  [19:0] sa_out,
    output reg         bale,
    output reg         aen,
    output reg         sbhe_n,
    output reg         memr_n,
    output reg         memw_n,
    output reg         osc_out,
    output reg         tc,
    // Data bus, two-way
    input  wire [15:0] sd_in,
    output reg  [15:0] sd_out,
    output reg         sd_oe,
    // Module claims and handshakes
    input  wire        memcs16_n,
    input  wire        iochrdy,
    input  wire        master_n,
    input  wire [7:0]  drq,
    input  wire [15:0] irq_in,
    output reg  [7:0]  dack_n,
    output reg         host_release
);
    localparam ST_IDLE = 6'h01;
    localparam ST_ADDR = 6'h02;
    localparam ST_CMD  = 6'h04;
    localparam ST_DMA  = 6'h08;
    localparam ST_MAST = 6'h10;
    localparam ST_END  = 6'h20;

    // Synchronised bus inputs, ready and master idle high
    wire [27:0] raw_in = {osc_in, memcs16_n, iochrdy, master_n, drq, irq_in};
    wire [27:0] rst_in = {1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 16'h0000};
    wire [27:0] syn;
    wire        osc_s     = syn[27];
    wire        cs16_s_n  = syn[26];
    wire        rdy_s     = syn[25];
    wire        mast_s_n  = syn[24];
    wire [7:0]  drq_s     = syn[23:16];
    wire [15:0] irq_s     = syn[15:0];

    isb_sync #(.WIDTH(28)) u_sync
    (
        .clock    (clock),
        .reset    (reset),
        .clk_en   (clk_en),
        .async_in (raw_in),
        .reset_val(rst_in),
        .sync_out (syn)
    );

    reg [5:0]  state_reg;
    reg [2:0]  cnt_reg;
    reg [2:0]  chan_reg;
    reg        wr_reg;
    reg        word_reg;
    reg [23:0] addr_reg;
    reg [15:0] wdata_reg;
    reg [7:0]  held_reg;

    // A served channel stays masked until its stale synchronised request clears
    wire [7:0] drq_ok = drq_s & ~held_reg;

    // Lowest numbered active request wins
    reg [2:0] pick;
    reg       any_drq;
    integer   k;
    always @*
    begin
        pick = 3'h0;
        any_drq = 1'b0;
        for (k = 7; k >= 0; k = k - 1)
        begin
            if (drq_ok[k])
            begin
                pick = k[2:0];
                any_drq = 1'b1;
            end
        end
    end

    // Oscillator is only re-timed and passed on; no logic runs on it
    always @(posedge clock)
    begin
        if (reset)
            osc_out <= 1'b0;
        else if (clk_en)
            osc_out <= osc_s;
    end

    always @(posedge clock)
    begin
        if (reset)
            irq_pending <= 8'h00;
        else if (clk_en)
            irq_pending <= {irq_s[15], irq_s[14], irq_s[12:10], irq_s[7], irq_s[6] | irq_s[5], irq_s[4] | irq_s[3]};
    end

    // ----------------------------------------------------------------
    // Bus cycle sequencer
    // ----------------------------------------------------------------
    always @(posedge clock)
    begin
        if (reset)
        begin
            state_reg    <= ST_IDLE;
            cnt_reg      <= 3'h0;
            chan_reg     <= 3'h0;
            wr_reg       <= 1'b0;
            word_reg     <= 1'b0;
            addr_reg     <= 24'h000000;
            wdata_reg    <= 16'h0000;
            la_out       <= 7'h00;
            sa_out       <= 20'h00000;
            bale         <= 1'b0;
            aen          <= 1'b0;
            sbhe_n       <= 1'b1;
            memr_n       <= 1'b1;
            memw_n       <= 1'b1;
            tc           <= 1'b0;
            sd_out       <= 16'h0000;
            sd_oe        <= 1'b0;
            dack_n       <= `ISB_DACK_IDLE;
            host_release <= 1'b0;
            cpu_done     <= 1'b0;
            cpu_rdata    <= 16'h0000;
            cpu_wide     <= 1'b0;
            held_reg     <= 8'h00;
        end
        else if (clk_en)
        begin
            cpu_done <= 1'b0;
            tc       <= 1'b0;
            held_reg <= held_reg & drq_s;
            case (state_reg)
                ST_IDLE:
                begin
                    if (any_drq)
                    begin
                        // Request is held by the module until this acknowledge
                        chan_reg  <= pick;
                        dack_n    <= ~(8'h01 << pick);
                        aen       <= 1'b1;
                        bale      <= 1'b1;
                        state_reg <= ST_DMA;
                    end
                    else if (cpu_req)
                    begin
                        addr_reg  <= cpu_addr;
                        wdata_reg <= cpu_wdata;
                        wr_reg    <= cpu_write;
                        word_reg  <= cpu_word;
                        la_out    <= cpu_addr[`ISB_LA_HI:`ISB_LA_LO];
                        sa_out    <= cpu_addr[19:0];
                        bale      <= 1'b1;
                        sbhe_n    <= ~(cpu_word | cpu_addr[0]);
                        cnt_reg   <= `ISB_ADDR_CYCLES;
                        state_reg <= ST_ADDR;
                    end
                end
                ST_ADDR:
                begin
                    // Falling latch enable marks the upper address valid to modules
                    bale      <= 1'b0;
                    memr_n    <= wr_reg;
                    memw_n    <= ~wr_reg;
                    sd_oe     <= wr_reg;
                    sd_out    <= addr_reg[0] & ~word_reg ? {wdata_reg[7:0], 8'h00} : wdata_reg;
                    cnt_reg   <= `ISB_CMD_CYCLES;
                    state_reg <= ST_CMD;
                end
                ST_CMD:
                begin
                    if (cnt_reg != 3'h0)
                        cnt_reg <= cnt_reg - 3'h1;
                    else if (rdy_s)
                    begin
                        cpu_rdata <= sd_in;
                        // Claim is sampled late, once the decode of this address has crossed
                        cpu_wide  <= ~cs16_s_n;
                        memr_n    <= 1'b1;
                        memw_n    <= 1'b1;
                        sd_oe     <= 1'b0;
                        sbhe_n    <= 1'b1;
                        cpu_done  <= 1'b1;
                        state_reg <= ST_END;
                    end
                end
                ST_DMA:
                begin
                    if (!mast_s_n)
                    begin
                        // Master owns the lines; host keeps only the acknowledge low until it lets go
                        host_release <= 1'b1;
                        aen          <= 1'b0;
                        bale         <= 1'b0;
                        state_reg    <= ST_MAST;
                    end
                    else if (!drq_s[chan_reg] || dma_last[chan_reg])
                    begin
                        tc        <= dma_last[chan_reg];
                        held_reg  <= (held_reg & drq_s) | (8'h01 << chan_reg);
                        dack_n    <= `ISB_DACK_IDLE;
                        aen       <= 1'b0;
                        bale      <= 1'b0;
                        state_reg <= ST_END;
                    end
                end
                ST_MAST:
                begin
                    if (mast_s_n)
                    begin
                        host_release <= 1'b0;
                        held_reg     <= (held_reg & drq_s) | (8'h01 << chan_reg);
                        dack_n       <= `ISB_DACK_IDLE;
                        state_reg    <= ST_END;
                    end
                end
                ST_END:
                begin
                    state_reg <= ST_IDLE;
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

//--- verif/isb_host_properties.sv
// Port checks for the stacked bus host
`timescale 1ns/1ps
module isb_host_properties
(
    // Clock and reset
    input wire clock,
    input wire reset,
    // Cycle side
    input wire cpu_req,
    input wire cpu_write,
    input wire [23:0] cpu_addr,
    input wire cpu_word,
    input wire cpu_done,
    // Bus side
    input wire [7:0] drq,
    input wire [7:0] dack_n,
    input wire memr_n,
    input wire memw_n,
    input wire sbhe_n,
    input wire bale,
    input wire aen,
    input wire tc,
    input wire sd_oe,
    input wire host_release
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    wire dma_on = dack_n != 8'hFF;
    chk_read_strobe: assert property ($fell(memr_n) |-> cpu_req && !cpu_write)
        else $error("read strobe outside read");
    chk_write_strobe: assert property ($fell(memw_n) |-> cpu_req && cpu_write && sd_oe)
        else $error("write strobe outside write");
    chk_strobe_done: assert property ($fell(memr_n) || $fell(memw_n) |-> ##[1:300] cpu_done)
        else $error("cycle never done");
    chk_byte_high: assert property (!memr_n || !memw_n |-> sbhe_n == !(cpu_word || cpu_addr[0]))
        else $error("byte high enable wrong");
    chk_dma_bale: assert property (dma_on && !host_release |-> aen && bale)
        else $error("dma without aen and bale");
    chk_dack_single: assert property ($onehot0(~dack_n))
        else $error("two acknowledges");
    chk_dack_grant: assert property ($rose(drq[0]) && !dma_on && !cpu_req |-> ##[1:20] !dack_n[0])
        else $error("request not acknowledged");
    chk_tc_pulse: assert property ($rose(tc) |-> $past(dma_on) ##1 !tc)
        else $error("bad terminal count");
    chk_release_ack: assert property ($rose(host_release) |-> dma_on)
        else $error("release without acknowledge");
    cover property (!memr_n && cpu_done);
    cover property ($rose(tc));
    cover property ($rose(host_release));
endmodule
bind isb_host isb_host_properties isb_host_properties_i (.clock(clock), .reset(reset),
    .cpu_req(cpu_req), .cpu_write(cpu_write), .cpu_addr(cpu_addr), .cpu_word(cpu_word),
    .cpu_done(cpu_done), .drq(drq), .dack_n(dack_n), .memr_n(memr_n), .memw_n(memw_n),
    .sbhe_n(sbhe_n), .bale(bale), .aen(aen), .tc(tc), .sd_oe(sd_oe), .host_release(host_release));

//--- verif/isb_mem_model.sv
// Memory module with master takeover on the far side of the bus
`timescale 1ns/1ps
module isb_mem_model
(
    input wire clock,
    input wire [23:17] la_out,
    input wire [19:0] sa_out,
    input wire sbhe_n,
    input wire bale,
    input wire aen,
    input wire memr_n,
    input wire memw_n,
    input wire [15:0] sd_out,
    input wire sd_oe,
    input wire [7:0] dack_n,
    input wire [7:0] waits,
    input wire dma_go,
    input wire take,
    input wire [2:0] ch,
    output wire [15:0] sd_in,
    output wire memcs16_n,
    output wire iochrdy,
    output wire [7:0] drq,
    output reg master_n
);
    reg [15:0] mem [0:15];
    reg [15:0] last;
    reg [7:0] cnt;
    reg [23:17] la_hold;
    wire [3:0] a = sa_out[4:1];
    // Select uses the held upper address and stays off while DMA owns the lines
    wire sel = !aen && (la_hold == 7'h00);
    assign memcs16_n = la_out != 7'h01;
    // Released bus flips each cycle so a stale value never matches
    assign sd_in = sd_oe ? sd_out : ((!memr_n && sel) ? mem[a] : ~last);
    assign iochrdy = (memr_n && memw_n) || cnt >= waits;
    assign drq = dma_go ? (8'h01 << ch) : 8'h00;
    initial master_n = 1'b1;
    always @(posedge clock)
    begin
        last <= sd_in;
        if (bale)
            la_hold <= la_out;
        cnt <= (memr_n && memw_n) ? 8'h00 : cnt + 8'h01;
        master_n <= !(take && dma_go && !dack_n[ch]);
        if (!memw_n && sel && !sbhe_n)
            mem[a][15:8] <= sd_in[15:8];
        if (!memw_n && sel && !sa_out[0])
            mem[a][7:0] <= sd_in[7:0];
    end
endmodule

//--- verif/tb_isb_host.sv
// Self-checking bench for the stacked bus host
`timescale 1ns/1ps
module tb_isb_host;
    reg clock, reset, clk_en, osc_in, cpu_req, cpu_write, cpu_word, dma_go, take, wq;
    reg [23:0] cpu_addr;
    reg [15:0] cpu_wdata, irq_in, q;
    reg [7:0] dma_last, waits;
    reg [2:0] ch;
    wire cpu_done, cpu_wide, bale, aen, sbhe_n, memr_n, memw_n, osc_out, tc, sd_oe;
    wire memcs16_n, iochrdy, master_n, host_release;
    wire [15:0] cpu_rdata, sd_in, sd_out;
    wire [7:0] irq_pending, drq, dack_n;
    wire [23:17] la_out;
    wire [19:0] sa_out;
    integer n_fail, tests_run, n, n0;
    isb_host isb_host_i (.clock(clock), .reset(reset), .clk_en(clk_en), .osc_in(osc_in),
        .cpu_req(cpu_req), .cpu_write(cpu_write), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_word(cpu_word), .cpu_done(cpu_done), .cpu_rdata(cpu_rdata), .cpu_wide(cpu_wide),
        .dma_last(dma_last), .irq_pending(irq_pending), .la_out(la_out), .sa_out(sa_out),
        .bale(bale), .aen(aen), .sbhe_n(sbhe_n), .memr_n(memr_n), .memw_n(memw_n),
        .osc_out(osc_out), .tc(tc), .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe),
        .memcs16_n(memcs16_n), .iochrdy(iochrdy), .master_n(master_n), .drq(drq),
        .irq_in(irq_in), .dack_n(dack_n), .host_release(host_release));
    isb_mem_model isb_mem_model_i (.clock(clock), .la_out(la_out), .sa_out(sa_out),
        .sbhe_n(sbhe_n), .memr_n(memr_n), .memw_n(memw_n), .sd_out(sd_out), .sd_oe(sd_oe),
        .bale(bale), .aen(aen),
        .dack_n(dack_n), .waits(waits), .dma_go(dma_go), .take(take), .ch(ch), .sd_in(sd_in),
        .memcs16_n(memcs16_n), .iochrdy(iochrdy), .drq(drq), .master_n(master_n));
    initial begin clock = 0; forever #50 clock = ~clock; end
    // Oscillator phase offset keeps it unrelated to the bus clock
    initial begin osc_in = 0; #137; forever #400 osc_in = ~osc_in; end
    // ----
    // Shared tasks
    // ----
    task check(input [15:0] seen, input [15:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp)
            begin
                n_fail = n_fail + 1;
                $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task tmo;
        if (n >= 300)
        begin
            check(16'h0000, 16'h0001);
            stop_test;
        end
    endtask
    task cyc(input w, input [23:0] a, input [15:0] d, input wd);
        begin
            @(negedge clock);
            cpu_req = 1; cpu_write = w; cpu_addr = a; cpu_wdata = d; cpu_word = wd; n = 0;
            while (cpu_done !== 1'b1 && n < 300) begin @(negedge clock); n = n + 1; end
            tmo;
            q = cpu_rdata; wq = cpu_wide; cpu_req = 0;
            @(negedge clock);
        end
    endtask
    // Odd byte lands in the high lane, word read sees both writes
    task t_mem;
        begin
            cyc(1, 24'h000004, 16'hA5C3, 1);
            cyc(1, 24'h000005, 16'h7E7E, 0);
            cyc(0, 24'h000004, 16'h0000, 1); check(q, 16'h7EC3);
            check({15'h0000, wq}, 16'h0000);
        end
    endtask
    task t_wide;
        begin
            cyc(0, 24'h020000, 16'h0000, 1); check({15'h0000, wq}, 16'h0001);
            cyc(0, 24'h040000, 16'h0000, 1); check({15'h0000, wq}, 16'h0000);
        end
    endtask
    task t_wait;
        begin
            cyc(0, 24'h000004, 16'h0000, 1); n0 = n;
            waits = 8'h05;
            cyc(0, 24'h000004, 16'h0000, 1); waits = 8'h00;
            check({15'h0000, (n >= n0 + 5)}, 16'h0001);
            check(q, 16'h7EC3);
        end
    endtask
    task t_dma;
        begin
            ch = 3'h3; dma_go = 1; n = 0;
            while (dack_n !== 8'hF7 && n < 300) begin @(negedge clock); n = n + 1; end
            tmo;
            check({14'h0000, aen, bale}, 16'h0003);
            dma_last = 8'h08; n = 0;
            while (tc !== 1'b1 && n < 300) begin @(negedge clock); n = n + 1; end
            tmo;
            dma_go = 0; dma_last = 8'h00; n = 0;
            while (dack_n !== 8'hFF && n < 300) begin @(negedge clock); n = n + 1; end
            tmo;
            // Stale request still in the synchroniser must not win a second grant
            repeat (3) @(negedge clock);
            check({15'h0000, tc}, 16'h0000);
            check({8'h00, dack_n}, 16'h00FF);
        end
    endtask
    task t_master;
        begin
            ch = 3'h0; take = 1; dma_go = 1; n = 0;
            while (host_release !== 1'b1 && n < 300) begin @(negedge clock); n = n + 1; end
            tmo;
            check({8'h00, dack_n}, 16'h00FE);
            // Host keeps off the lines while the new master settles
            repeat (2) @(negedge clock);
            check({10'h000, host_release, memr_n, memw_n, sd_oe, aen, bale}, 16'h0038);
            dma_go = 0; take = 0; n = 0;
            while ((host_release | ~&dack_n) !== 1'b0 && n < 300) begin @(negedge clock); n = n + 1; end
            tmo;
        end
    endtask
    task t_irq_osc;
        begin
            clk_en = 0; irq_in = 16'h0010;
            repeat (10) @(negedge clock);
            check({8'h00, irq_pending}, 16'h0000);
            clk_en = 1; n = 0;
            while (irq_pending === 8'h00 && n < 300) begin @(negedge clock); n = n + 1; end
            tmo;
            irq_in = 16'h0000; n = 0;
            while (irq_pending !== 8'h00 && n < 300) begin @(negedge clock); n = n + 1; end
            tmo;
            n0 = 0; q[0] = osc_out;
            repeat (40) begin @(negedge clock); n0 = n0 + (osc_out !== q[0]); q[0] = osc_out; end
            check({15'h0000, (n0 >= 8)}, 16'h0001);
        end
    endtask
    initial
    begin
        n_fail = 0; tests_run = 0; reset = 1; cpu_req = 0; cpu_write = 0; cpu_word = 0;
        cpu_addr = 24'h000000; cpu_wdata = 16'h0000; irq_in = 16'h0000; dma_last = 8'h00;
        waits = 8'h00; dma_go = 0; take = 0; ch = 3'h0; clk_en = 1;
        repeat (4) @(negedge clock);
        reset = 0;
        repeat (5) @(negedge clock);
        t_mem;
        t_wide;
        t_wait;
        t_dma;
        t_master;
        t_irq_osc;
        stop_test;
    end
endmodule
